/* File: verilog/pmp_pkg.sv */
// Package for the parallel port controller: register map, fields, states.
// Assumes a 32-bit Wishbone register bus with byte addresses.
package pmp_pkg;
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] OFS_CTL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_MODE = 5'h04;
  localparam logic [ADR_W-1:0] OFS_ADDR = 5'h08;
  localparam logic [ADR_W-1:0] OFS_DATA = 5'h0c;
  localparam logic [ADR_W-1:0] OFS_STAT = 5'h10;
  localparam logic [ADR_W-1:0] OFS_MASK = 5'h14;
  // Control register fields
  localparam int B_EN = 15;
  localparam int B_IDL = 13;
  localparam int B_MUX = 11;
  localparam int B_BEE = 10;
  localparam int B_WRE = 9;
  localparam int B_RDE = 8;
  localparam int B_CSF = 6;
  localparam int B_ALP = 5;
  localparam int B_CSP = 3;
  localparam int B_BEP = 2;
  localparam int B_WRP = 1;
  localparam int B_RDP = 0;
  localparam logic [15:0] CTL_WMASK = 16'hbfef;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Mode register fields
  localparam int B_BUSY = 15;
  localparam int B_INTERRUPT_REQUEST_MODE = 13;
  localparam int B_ADDRESS_INCREMENT_MODE = 11;
  localparam int B_W16 = 10;
  localparam int B_MODE = 8;
  localparam int B_WB = 6;
  localparam int B_WM = 2;
  localparam int B_WE = 0;
  localparam logic [15:0] MODE_WMASK = 16'h7fff;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam int INC_BITS = 11;
  localparam int ADDR_HI_BIT = 14;
  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int S_PORT = 0;
  localparam int S_DONE = 1;
  localparam logic [1:0] MUX_NONE = 2'b00;
  localparam logic [1:0] MUX_LOW = 2'b01;
  localparam logic [1:0] MUX_FULL = 2'b10;
  localparam logic [1:0] MD_LEGACY = 2'b00;
  localparam logic [1:0] MD_ENH = 2'b01;
  localparam logic [1:0] MD_M2 = 2'b10;
  localparam logic [1:0] MD_M1 = 2'b11;
  localparam logic [1:0] IRQ_EVERY = 2'b01;
  localparam logic [1:0] IRQ_BUF3 = 2'b11;
  localparam logic [1:0] INC_ADDR = 2'b01;
  localparam logic [1:0] INC_BUF = 2'b11;
  localparam logic [1:0] CSF_CS = 2'b10;
  localparam logic [1:0] LAST_BUF = 2'b11;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ALO = 6'b000010,
    ST_AHI = 6'b000100,
    ST_SETUP = 6'b001000,
    ST_STRB = 6'b010000,
    ST_HOLD = 6'b100000
  } mst_e;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [1:0] a;
    logic [7:0] d;
  } host_in_s;
endpackage

/* File: verilog/parallel_master_slave_port_ctrl.sv */
// Parallel 8-bit port: master cycles to memory, slave service to a host.
// Assumes Wishbone classic master on mclk; pin inputs are asynchronous.
// Functional notes
// - Mux select places address on data pins
// - Pin enables release unused strobe pins
// - Select-one pin: chip select or address 14
// - Latch and select polarity bits honoured
// - Polarity ignored when pin carries address
// - Mode 11 interrupts on buffer three access
// - Mode 01 every cycle, mode 00 none
// - Address counter increments per byte transferred
// - Master modes one and two strobes
// - Slave modes legacy and addressable
// - Wait states in instruction cycles
// - Zero strobe wait skips setup, hold
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module parallel_master_slave_port_ctrl
  import pmp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cpu_idle,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Port pins
  input wire host_in_s pins_i,
  output logic [15:0] port_address_pins,
  output logic port_address_oe,
  output logic [7:0] port_data_pins_o,
  output logic port_data_oe,
  output logic select_one_pin_o,
  output logic select_one_oe,
  output logic read_strobe_pin_o,
  output logic read_strobe_oe,
  output logic write_strobe_pin_o,
  output logic write_strobe_oe,
  output logic byte_enable_pin_o,
  output logic byte_enable_oe,
  output logic low_address_latch_strobe,
  output logic high_address_latch_strobe
);
  logic [15:0] ctl, mode, addr, wdata, rdata;
  logic [IRQ_W-1:0] stat, mask;
  logic [7:0] in_buf [4];
  logic [7:0] out_buf [4];
  logic [1:0] rd_ptr, wr_ptr;
  host_in_s s1, s2;
  logic prev_rd, prev_wr;
  logic [7:0] prev_d;
  mst_e st;
  logic [3:0] cnt;
  logic is_read, byte_sel;

  function automatic logic [3:0] phase_len(input logic [1:0] f);
    return {2'b00, f} + 4'h1;
  endfunction
  function automatic logic [15:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[1]}}, {8{sel[0]}}};
  endfunction
  function automatic logic act_lvl(input logic act, input logic pol);
    return act ~^ pol;
  endfunction

  // Decoded fields
  wire en = ctl[B_EN];
  wire run = en & ~(ctl[B_IDL] & cpu_idle);
  wire [1:0] mux = ctl[B_MUX+:2];
  wire [1:0] chip_select_function = ctl[B_CSF+:2];
  wire [1:0] interrupt_request_mode = mode[B_INTERRUPT_REQUEST_MODE+:2];
  wire [1:0] address_increment_mode = mode[B_ADDRESS_INCREMENT_MODE+:2];
  wire wide = mode[B_W16];
  wire [1:0] md = mode[B_MODE+:2];
  wire [1:0] wb_f = mode[B_WB+:2];
  wire [3:0] wm = mode[B_WM+:4];
  wire [1:0] we_f = mode[B_WE+:2];
  wire master = md[1];
  wire busy = (st != ST_IDLE);

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_go = req & wb_we_i & wb_ack_o;
  wire rd_go = req & ~wb_we_i & wb_ack_o;
  wire [15:0] bm = lane_mask(wb_sel_i);
  wire [15:0] wd = wb_dat_i[15:0];
  wire hit_ctl = (wb_adr_i == OFS_CTL);
  wire hit_mode = (wb_adr_i == OFS_MODE);
  wire hit_addr = (wb_adr_i == OFS_ADDR);
  wire hit_data = (wb_adr_i == OFS_DATA);
  wire hit_stat = (wb_adr_i == OFS_STAT);
  wire hit_mask = (wb_adr_i == OFS_MASK);
  wire [1:0] sw_idx = addr[1:0];
  wire [15:0] rd_mux = hit_ctl ? ctl :
    hit_mode ? {busy, mode[14:0]} :
    hit_addr ? addr :
    hit_data ? (master ? rdata : {8'h00, in_buf[sw_idx]}) :
    hit_stat ? {{(16-IRQ_W){1'b0}}, stat} :
    hit_mask ? {{(16-IRQ_W){1'b0}}, mask} : 16'h0000;

  // Master start: data write or read while idle
  wire start = run & master & ~busy & hit_data & (wr_go | rd_go);
  wire strb_end = (st == ST_STRB) & (cnt == 4'h0);
  wire hold_end = (st == ST_HOLD) & (cnt == 4'h0);
  wire byte_end = (strb_end & (wm == 4'h0)) | hold_end;
  wire second = wide & ~byte_sel;
  wire [3:0] setup_n = phase_len(wb_f) - 4'h1;
  wire [3:0] hold_n = phase_len(we_f) - 4'h1;
  wire mux_on = (mux == MUX_LOW) | (mux == MUX_FULL);

  // Slave side strobes
  wire s_cs = (s2.cs == ctl[B_CSP]);
  wire s_rd = s_cs & (s2.rd == ctl[B_RDP]);
  wire s_wr = s_cs & (s2.wr == ctl[B_WRP]);
  wire slave_on = run & ~master;
  wire rd_end = slave_on & prev_rd & ~s_rd;
  wire wr_end = slave_on & prev_wr & ~s_wr;
  wire buffered = (md == MD_LEGACY) & (address_increment_mode == INC_BUF);
  wire [1:0] ridx = (md == MD_ENH) ? s2.a : (buffered ? rd_ptr : 2'b00);
  wire [1:0] widx = (md == MD_ENH) ? s2.a : (buffered ? wr_ptr : 2'b00);
  wire buf3 = (rd_end & (ridx == LAST_BUF)) | (wr_end & (widx == LAST_BUF));
  wire cyc_any = byte_end | rd_end | wr_end;
  wire port_ev = (interrupt_request_mode == IRQ_BUF3) ? buf3 :
    (interrupt_request_mode == IRQ_EVERY) ? cyc_any : 1'b0;
  wire [IRQ_W-1:0] set_v = {byte_end & ~second, port_ev};
  wire [IRQ_W-1:0] clr_v = (wr_go & hit_stat) ? wd[IRQ_W-1:0] : '0;

  // Bus slave, registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctl <= CTL_RESET;
      mode <= MODE_RESET;
      mask <= '0;
      stat <= '0;
      wdata <= 16'h0000;
    end else if (ce) begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= {16'h0000, rd_mux};
      stat <= (stat & ~clr_v) | set_v;
      if (wr_go & hit_ctl) begin
        ctl <= (ctl & ~(bm & CTL_WMASK)) | (wd & bm & CTL_WMASK);
      end
      if (wr_go & hit_mode) begin
        mode <= (mode & ~(bm & MODE_WMASK)) | (wd & bm & MODE_WMASK);
      end
      if (wr_go & hit_mask) begin
        mask <= wd[IRQ_W-1:0];
      end
      if (wr_go & hit_data & ~busy) begin
        wdata <= (wdata & ~bm) | (wd & bm);
      end
    end
  end

  assign irq = |(stat & mask);

  // Master cycle sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      is_read <= 1'b0;
      byte_sel <= 1'b0;
      rdata <= 16'h0000;
      addr <= 16'h0000;
    end else if (ce) begin
      if (wr_go & hit_addr) begin
        addr <= (addr & ~bm) | (wd & bm);
      end else if (byte_end & (address_increment_mode == INC_ADDR)) begin
        addr[INC_BITS-1:0] <= addr[INC_BITS-1:0] + 11'h001;
      end
      if (strb_end & is_read) begin
        rdata[{byte_sel, 3'b000}+:8] <= s2.d;
      end
      case (st)
        ST_IDLE: begin
          if (start) begin
            is_read <= rd_go;
            byte_sel <= 1'b0;
            st <= mux_on ? ST_ALO : (wm == 4'h0 ? ST_STRB : ST_SETUP);
            cnt <= mux_on ? setup_n : (wm == 4'h0 ? 4'h0 : setup_n);
          end
        end
        ST_ALO: begin
          if (cnt == 4'h0) begin
            st <= (mux == MUX_FULL) ? ST_AHI :
              (wm == 4'h0 ? ST_STRB : ST_SETUP);
            cnt <= (mux == MUX_FULL || wm != 4'h0) ? setup_n : 4'h0;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_AHI: begin
          if (cnt == 4'h0) begin
            st <= (wm == 4'h0) ? ST_STRB : ST_SETUP;
            cnt <= (wm == 4'h0) ? 4'h0 : setup_n;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_SETUP: begin
          if (cnt == 4'h0) begin
            st <= ST_STRB;
            cnt <= wm;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_STRB: begin
          if (cnt == 4'h0) begin
            st <= (wm == 4'h0) ? ST_IDLE : ST_HOLD;
            cnt <= hold_n;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_HOLD: begin
          if (cnt == 4'h0) begin
            st <= ST_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: st <= ST_IDLE;
      endcase
      if (byte_end & second) begin
        byte_sel <= 1'b1;
        st <= mux_on ? ST_ALO : (wm == 4'h0 ? ST_STRB : ST_SETUP);
        cnt <= (mux_on || wm != 4'h0) ? setup_n : 4'h0;
      end
    end
  end

  // Slave sync and buffers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      prev_rd <= 1'b0;
      prev_wr <= 1'b0;
      rd_ptr <= 2'b00;
      wr_ptr <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        in_buf[i] <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else if (ce) begin
      s1 <= pins_i;
      s2 <= s1;
      prev_rd <= s_rd;
      prev_wr <= s_wr;
      if (wr_end) begin
        in_buf[widx] <= prev_d;
      end
      if (wr_go & hit_data & ~master & wb_sel_i[0]) begin
        out_buf[sw_idx] <= wd[7:0];
      end
      if (buffered & rd_end) begin
        rd_ptr <= rd_ptr + 2'b01;
      end
      if (buffered & wr_end) begin
        wr_ptr <= wr_ptr + 2'b01;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_d <= 8'h00;
    end else if (ce) begin
      prev_d <= s2.d;
    end
  end

  // Pin drive
  wire mst_drv = en & master;
  wire strb = (st == ST_STRB);
  wire data_ph = (st == ST_SETUP) | strb | (st == ST_HOLD);
  wire m1 = (md == MD_M1);
  wire cs_fn = (chip_select_function == CSF_CS);
  assign port_address_pins = addr;
  assign port_address_oe = mst_drv & (mux != MUX_FULL);
  assign port_data_pins_o = (st == ST_ALO) ? addr[7:0] :
    (st == ST_AHI) ? addr[15:8] :
    master ? wdata[{byte_sel, 3'b000}+:8] : out_buf[ridx];
  assign port_data_oe = (mst_drv & ((st == ST_ALO) | (st == ST_AHI) |
    (data_ph & ~is_read))) | (en & slave_on & s_rd);
  assign select_one_pin_o = cs_fn ? act_lvl(busy, ctl[B_CSP]) :
    addr[ADDR_HI_BIT];
  assign select_one_oe = mst_drv;
  assign read_strobe_pin_o = act_lvl(m1 ? is_read : (strb & is_read),
    ctl[B_RDP]);
  assign read_strobe_oe = mst_drv & ctl[B_RDE];
  assign write_strobe_pin_o = act_lvl(m1 ? strb : (strb & ~is_read),
    ctl[B_WRP]);
  assign write_strobe_oe = mst_drv & ctl[B_WRE];
  assign byte_enable_pin_o = act_lvl(byte_sel & busy, ctl[B_BEP]);
  assign byte_enable_oe = mst_drv & wide & ctl[B_BEE];
  assign low_address_latch_strobe = act_lvl(st == ST_ALO,
    ctl[B_ALP]);
  assign high_address_latch_strobe = act_lvl(st == ST_AHI,
    ctl[B_ALP]);

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_off_quiet;
    !en |-> !(port_data_oe | read_strobe_oe | write_strobe_oe |
      select_one_oe | byte_enable_oe | port_address_oe);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("Pins driven while port disabled");

  property p_mux_addr;
    (st == ST_ALO) |-> port_data_pins_o == addr[7:0] && port_data_oe;
  endproperty
  a_mux_addr: assert property (p_mux_addr)
    else $error("Low address not on data pins");

  property p_rd_release;
    !ctl[B_RDE] |-> !read_strobe_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("Read strobe driven while released");

  property p_sel_addr;
    (!chip_select_function[1] && busy) |-> select_one_pin_o == addr[ADDR_HI_BIT];
  endproperty
  a_sel_addr: assert property (p_sel_addr)
    else $error("Select pin does not follow address bit");

  property p_busy;
    start |=> busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy not raised after start");

  property p_every;
    (ce && interrupt_request_mode == IRQ_EVERY && byte_end) |=> stat[S_PORT];
  endproperty
  a_every: assert property (p_every)
    else $error("Cycle end did not flag interrupt");

  property p_inc;
    (ce && byte_end && address_increment_mode == INC_ADDR && !(wr_go && hit_addr)) |=>
      addr[INC_BITS-1:0] == $past(addr[INC_BITS-1:0]) + 11'h001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("Address did not advance by one");

  sequence s_strobe3;
    strb [*4] ##1 !strb;
  endsequence
  property p_strobe_len;
    (ce && st == ST_SETUP && cnt == 4'h0 && wm == 4'h3) |=> s_strobe3;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("Strobe phase length wrong");

  property p_zero_wait;
    (wm == 4'h0) |-> st != ST_SETUP && st != ST_HOLD;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("Setup or hold used with zero strobe wait");

  property p_order;
    (ce && st == ST_SETUP) |=> (st == ST_SETUP || st == ST_STRB);
  endproperty
  a_order: assert property (p_order)
    else $error("Setup not followed by strobe");
endmodule

/* File: verification/port_memory_model.sv */
// External byte memory behind the port in master mode 2; in master mode 1 it serves writes only, as its strobe also stores during reads.
// Assumes active-low strobes and unmultiplexed address pins.
`timescale 1ns/100ps
module port_memory_model (
  // Clock of the port
  input wire logic clk,
  // Address and data from the port
  input wire logic [15:0] addr,
  input wire logic [7:0] din,
  // Strobes and their enables
  input wire logic rd_n,
  input wire logic rd_oe,
  input wire logic wr_n,
  input wire logic wr_oe,
  // Data back to the port
  output logic [7:0] dout
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  wire drive = rd_oe && !rd_n;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // Store at each clock edge inside the strobe, clear of address updates
  always @(posedge clk) begin
    if (wr_oe && !wr_n) mem[addr[7:0]] <= din;
  end
  always @* begin
    if (drive) last = mem[addr[7:0]];
  end
  // Released bus shows the inverse, never a stale match
  assign dout = drive ? mem[addr[7:0]] : ~last;
endmodule

/* File: verification/parallel_master_slave_port_ctrl_tb.sv */
// Bench: registers, master cycles, wait states, polarity, interrupts.
// Assumes the byte memory model on the port pins and a 50 MHz clock.
`timescale 1ns/100ps
module parallel_master_slave_port_ctrl_tb;
  import pmp_pkg::*;
  logic mclk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0;
  logic rd_chk = 0, mon = 1, first_busy;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat, dat_o;
  logic ack, irq, lat_lo, sel_o, rd_o, rd_oe, wr_o, wr_oe, be_o, be_oe;
  logic [15:0] pa, a, d;
  logic [7:0] pd_o, md;
  logic [63:0] q;
  host_in_s host;
  int err_total = 0, check_count = 0, wcnt = 0, seed = 32'h89cd1003;
  int lcnt = 0, bcnt = 0, l0;
  logic [63:0] exp_rd[$];
  int exp_w[$];
  logic [15:0] pc[4] = '{16'h8782, 16'h87a0, 16'h8708, 16'h8788};
  logic [2:0] pe[4] = '{3'b110, 3'b011, 3'b111, 3'b101};
  logic [3:0] wmv[4] = '{4'h0, 4'h1, 4'h3, 4'hf};
  logic [1:0] wbv[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  logic [1:0] wev[4] = '{2'h3, 2'h0, 2'h2, 2'h1};

  always #10 mclk = ~mclk;
  assign host = '{cs: 1'b1, rd: 1'b1, wr: 1'b1, a: 2'b00, d: md};

  parallel_master_slave_port_ctrl dut_u (
    .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .cpu_idle(1'b0),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq(irq), .pins_i(host), .port_address_pins(pa),
    .port_address_oe(), .port_data_pins_o(pd_o), .port_data_oe(),
    .select_one_pin_o(sel_o), .select_one_oe(),
    .read_strobe_pin_o(rd_o), .read_strobe_oe(rd_oe),
    .write_strobe_pin_o(wr_o), .write_strobe_oe(wr_oe),
    .byte_enable_pin_o(be_o), .byte_enable_oe(be_oe),
    .low_address_latch_strobe(lat_lo), .high_address_latch_strobe()
  );
  port_memory_model mdl_u (
    .clk(mclk), .addr(pa), .din(pd_o), .rd_n(rd_o), .rd_oe(rd_oe),
    .wr_n(wr_o), .wr_oe(wr_oe), .dout(md)
  );

  function logic [15:0] mw(logic w, logic [1:0] b, logic [3:0] m,
                           logic [1:0] e);
    return {1'b0, 2'b01, 2'b01, w, 2'b10, b, m, e};
  endfunction

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Classic single cycle: hold until ack, then one idle cycle
  task wb(input logic w, input logic [ADR_W-1:0] ad,
          input logic [31:0] dt, input logic c);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    rd_chk <= c;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 0, 1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    rd_chk <= 1'b0;
  endtask

  task rdx(input logic [ADR_W-1:0] ad, input logic [31:0] e,
           input logic [31:0] m);
    exp_rd.push_back({m, e});
    wb(1'b0, ad, 32'h0, 1'b1);
  endtask

  task idle_wait;
    int n;
    n = 0;
    do begin
      wb(1'b0, OFS_MODE, 32'h0, 1'b0);
      if (n == 0) first_busy = rdat[B_BUSY];
      n++;
    end while (rdat[B_BUSY] !== 1'b0 && n < 100);
    chk("busy", rdat[B_BUSY], 0);
  endtask

  // Watcher: read data and write strobe widths against notes
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && rd_chk) begin
      if (exp_rd.size() == 0) chk("rd queue", 1, 0);
      else begin
        q = exp_rd.pop_front();
        chk("rd data", dat_o & q[63:32], q[31:0]);
      end
    end
    if (mon && wr_oe === 1'b1 && wr_o === 1'b0) wcnt <= wcnt + 1;
    else if (wcnt != 0) begin
      if (exp_w.size() == 0) chk("strobe", 1, 0);
      else chk("strobe width", wcnt, exp_w.pop_front());
      wcnt <= 0;
    end
    if (mon && lat_lo === 1'b0) lcnt <= lcnt + 1;
    if (mon && be_oe === 1'b1 && be_o === 1'b0) bcnt <= bcnt + 1;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    stop_test;
  end

  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    wb(1'b1, 5'h18, 32'h5a5a, 1'b0);
    for (int i = 0; i < 32; i += 4) rdx(5'(i), 32'h0, 32'hffff);
    wb(1'b1, OFS_CTL, 32'hffff, 1'b0);
    rdx(OFS_CTL, CTL_WMASK, 32'hffff);
    wb(1'b1, OFS_CTL, 32'h0, 1'b0);
    wb(1'b1, OFS_MODE, 32'hffff, 1'b0);
    rdx(OFS_MODE, MODE_WMASK, 32'hffff);
    wb(1'b1, OFS_DATA, 32'h00a5, 1'b0);
    repeat (40) @(posedge mclk);
    chk("wr oe", wr_oe, 0);
    rdx(OFS_ADDR, 32'h0, 32'hffff);
    wb(1'b1, OFS_MODE, mw(1'b0, 2'h0, 4'h1, 2'h0), 1'b0);
    wb(1'b1, OFS_ADDR, 32'h4000, 1'b0);
    mon = 0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_CTL, pc[i], 1'b0);
      @(negedge mclk);
      chk("pins", {lat_lo, sel_o, wr_o}, pe[i]);
    end
    wb(1'b1, OFS_CTL, 32'h8780, 1'b0);
    @(negedge mclk);
    mon = 1;
    for (int i = 0; i < 4; i++) begin
      a = $random(seed) & 16'h00fe;
      d = $random(seed) & 16'h00ff;
      wb(1'b1, OFS_MODE, mw(1'b0, wbv[i], wmv[i], wev[i]), 1'b0);
      wb(1'b1, OFS_ADDR, a, 1'b0);
      exp_w.push_back(wmv[i] + 1);
      wb(1'b1, OFS_DATA, d, 1'b0);
      idle_wait;
      chk("mem", mdl_u.mem[a[7:0]], d[7:0]);
      rdx(OFS_ADDR, a + 16'h1, 32'h07ff);
    end
    chk("busy seen", first_busy, 1);
    a = $random(seed) & 16'h00fe;
    d = 16'($random(seed));
    wb(1'b1, OFS_MODE, mw(1'b1, 2'h0, 4'h2, 2'h0), 1'b0);
    wb(1'b1, OFS_ADDR, a, 1'b0);
    exp_w.push_back(3);
    exp_w.push_back(3);
    wb(1'b1, OFS_DATA, d, 1'b0);
    idle_wait;
    chk("mem lo", mdl_u.mem[a[7:0]], d[7:0]);
    chk("mem hi", mdl_u.mem[a[7:0] + 8'h1], d[15:8]);
    chk("byte enable", bcnt, 5);
    rdx(OFS_ADDR, a + 16'h2, 32'h07ff);
    wb(1'b1, OFS_MODE, mw(1'b0, 2'h0, 4'h2, 2'h0), 1'b0);
    wb(1'b1, OFS_ADDR, a, 1'b0);
    wb(1'b0, OFS_DATA, 32'h0, 1'b0);
    idle_wait;
    rdx(OFS_DATA, mdl_u.mem[a[7:0]], 32'h00ff);
    idle_wait;
    // Master mode 1, low address byte multiplexed, select pin as address
    a = 16'($random(seed)) & 16'h00fe;
    d = 16'($random(seed)) & 16'h00ff;
    wb(1'b1, OFS_MODE, mw(1'b0, 2'h1, 4'h1, 2'h0) | 16'h0100, 1'b0);
    wb(1'b1, OFS_CTL, 32'h8f00, 1'b0);
    wb(1'b1, OFS_ADDR, a | 16'h4000, 1'b0);
    exp_w.push_back(2);
    l0 = lcnt;
    wb(1'b1, OFS_DATA, d, 1'b0);
    idle_wait;
    chk("mem m1", mdl_u.mem[a[7:0]], d[7:0]);
    chk("latch width", lcnt - l0, 2);
    @(negedge mclk);
    chk("irq masked", irq, 0);
    rdx(OFS_STAT, 32'h3, 32'h3);
    wb(1'b1, OFS_MASK, 32'h3, 1'b0);
    @(negedge mclk);
    chk("irq", irq, 1);
    wb(1'b1, OFS_STAT, 32'h1, 1'b0);
    rdx(OFS_STAT, 32'h2, 32'h3);
    wb(1'b1, OFS_MASK, 32'h1, 1'b0);
    @(negedge mclk);
    chk("irq off", irq, 0);
    wb(1'b1, OFS_STAT, 32'h2, 1'b0);
    rdx(OFS_STAT, 32'h0, 32'h3);
    @(posedge mclk);
    chk("strobes left", exp_w.size(), 0);
    chk("reads left", exp_rd.size(), 0);
    stop_test;
  end
endmodule
